// ===== common/pse_seq_map.svh
// Timing and strap constants of the port sequencer.
// Assumes a 10 MHz controller clock; included by bare name.
`ifndef PSE_SEQ_MAP_SVH
`define PSE_SEQ_MAP_SVH

// ----------------------------------------------------------------
// Timing figures as printed, and their cycle counts at 10 MHz
// ----------------------------------------------------------------
`define CLK_HZ          10000000
`define ZERO_MS         250
`define STEP_MS         20
`define DET_PERIOD_MS   320
`define CLASS_MS        20
`define RAMP_MS         30
`define OC_MS           60
`define DISC_MS         350
`define BACKOFF_MS      2000
`define RST_BACKOFF_MS  2200
`define CONV_KHZ        250
`define BLINK_HZ        10
`define ZERO_CYC        (`ZERO_MS * (`CLK_HZ / 1000))
`define STEP_CYC        (`STEP_MS * (`CLK_HZ / 1000))
`define DET_PERIOD_CYC  (`DET_PERIOD_MS * (`CLK_HZ / 1000))
`define CLASS_CYC       (`CLASS_MS * (`CLK_HZ / 1000))
`define RAMP_CYC        (`RAMP_MS * (`CLK_HZ / 1000))
`define OC_CYC          (`OC_MS * (`CLK_HZ / 1000))
`define DISC_CYC        (`DISC_MS * (`CLK_HZ / 1000))
`define BACKOFF_CYC     (`BACKOFF_MS * (`CLK_HZ / 1000))
`define RST_BACKOFF_CYC (`RST_BACKOFF_MS * (`CLK_HZ / 1000))
`define CONV_HALF_CYC   (`CLK_HZ / (`CONV_KHZ * 1000 * 2))
`define BLINK_HALF_CYC  (`CLK_HZ / (`BLINK_HZ * 2))
`define OC_DOWN_DIV     16

// ----------------------------------------------------------------
// Strap codes (index of the table row, 0 = pin at rail)
// ----------------------------------------------------------------
`define STRAP_W         4
`define STRAP_ROWS      12

`endif

// ===== common/pse_seq_pkg.sv
// Types of the port sequencer.
// Assumes pse_seq_map.svh sits on the include path.
package pse_seq_pkg;

  typedef enum logic [3:0] {
    ST_OFF      = 4'b0000,
    ST_ZERO     = 4'b0001,
    ST_STEP1    = 4'b0010,
    ST_STEP2    = 4'b0011,
    ST_STEP3    = 4'b0100,
    ST_DET_WAIT = 4'b0101,
    ST_CLASS    = 4'b0110,
    ST_RAMP     = 4'b0111,
    ST_POWERED  = 4'b1000,
    ST_ERROR    = 4'b1001,
    ST_BACKOFF  = 4'b1010
  } seq_state_t;

  typedef enum logic [1:0] {
    LVL_15W4 = 2'b00,
    LVL_7W0  = 2'b01,
    LVL_4W0  = 2'b10
  } power_level_t;

  // Detection output drive level
  typedef enum logic [1:0] {
    DRV_ZERO = 2'b00,
    DRV_4V5  = 2'b01,
    DRV_7V5  = 2'b10
  } det_drive_t;

  // Class 3 and 4 share one code
  typedef enum logic [1:0] {
    CLS_0  = 2'b00,
    CLS_1  = 2'b01,
    CLS_2  = 2'b10,
    CLS_34 = 2'b11
  } pd_class_t;

  typedef enum logic [1:0] {
    CUT_400 = 2'b00,
    CUT_98  = 2'b01,
    CUT_180 = 2'b10
  } cut_sel_t;

endpackage : pse_seq_pkg

// ===== common/oc_timer_if.sv
// Carrier between the sequencer and its overcurrent timer.
// Assumes both ends share the controller clock.
`timescale 1ns/1ps
interface oc_timer_if;
  logic run;
  logic over;
  logic fault;

  modport seq (output run, output over, input fault);
  modport tmr (input run, input over, output fault);
endinterface : oc_timer_if

// ===== rtl/oc_timer.sv
// Overcurrent integrator: counts up while over threshold, down at 1/16.
// Assumes the over flag is already synchronised to i_clk.
`timescale 1ns/1ps
`include "pse_seq_map.svh"
module oc_timer #(
  parameter int OC_CYC = `OC_CYC
) (
  input  wire logic  i_clk,
  input  wire logic  i_nrst,
  oc_timer_if.tmr    tif
);
  localparam int CW = $clog2(OC_CYC + 1);
  localparam logic [CW-1:0] LIMIT = CW'(OC_CYC);

  logic [CW-1:0] cnt_reg;
  logic [3:0]    div_reg;
  logic          fault_reg;
  wire           down_tick = (div_reg == 4'hf);
  wire           at_limit  = (cnt_reg >= LIMIT - CW'(1));

  assign tif.fault = fault_reg;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_reg   <= '0;
      div_reg   <= 4'h0;
      fault_reg <= 1'b0;
    end else if (!tif.run) begin
      cnt_reg   <= '0;
      div_reg   <= 4'h0;
      fault_reg <= 1'b0;
    end else if (tif.over) begin
      div_reg <= 4'h0;
      if (at_limit) begin
        fault_reg <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + CW'(1);
      end
    end else begin
      div_reg <= div_reg + 4'h1;
      if (down_tick && cnt_reg != '0) begin
        cnt_reg <= cnt_reg - CW'(1);
      end
    end
  end
endmodule : oc_timer

// ===== rtl/pse_port_seq.sv
// Single-port power-sourcing sequencer: strap, detection, class, power.
// Assumes a digital front end delivering decoded compare results (pins).
`timescale 1ns/1ps
`include "pse_seq_map.svh"

module pse_port_seq #(
  parameter int ZERO_CYC        = `ZERO_CYC,
  parameter int STEP_CYC        = `STEP_CYC,
  parameter int DET_PERIOD_CYC  = `DET_PERIOD_CYC,
  parameter int CLASS_CYC       = `CLASS_CYC,
  parameter int RAMP_CYC        = `RAMP_CYC,
  parameter int OC_CYC          = `OC_CYC,
  parameter int DISC_CYC        = `DISC_CYC,
  parameter int BACKOFF_CYC     = `BACKOFF_CYC,
  parameter int RST_BACKOFF_CYC = `RST_BACKOFF_CYC,
  parameter int BLINK_HALF_CYC  = `BLINK_HALF_CYC,
  parameter int CONV_HALF_CYC   = `CONV_HALF_CYC
) (
  input  wire logic                i_clk,
  input  wire logic                i_nrst,
  input  wire logic [`STRAP_W-1:0] i_strap_level,
  input  wire logic                i_strap_valid,
  input  wire logic                i_undervoltage_lockout,
  input  wire logic                i_valid_signature_window,
  input  wire logic [1:0]          i_class_current_sense,
  input  wire logic                i_over_threshold,
  input  wire logic                i_below_hold_current,
  input  wire logic                i_over_power,
  input  wire logic                i_ramp_done,
  input  wire logic                i_open_circuit,
  output logic                     o_conv_clk,
  output logic                     o_switcher_transistor,
  output logic                     o_pass_transistor,
  output logic [1:0]               o_det_drive,
  output logic                     o_class_mode,
  output logic                     o_ramp_en,
  output logic [1:0]               o_overload_threshold,
  output logic                     o_status_indicator,
  output logic                     o_status_pin_oe_n,
  output logic [1:0]               o_class,
  output logic [1:0]               o_power_level,
  output logic                     o_midspan,
  output logic                     o_error
);
  // ----------------------------------------------------------------
  // Synchronisers and constants
  // ----------------------------------------------------------------
  localparam int TW = 26;
  localparam logic [TW-1:0] T_ZERO  = TW'(ZERO_CYC - 1);
  localparam logic [TW-1:0] T_STEP  = TW'(STEP_CYC - 1);
  localparam logic [TW-1:0] T_PER   = TW'(DET_PERIOD_CYC - 1);
  localparam logic [TW-1:0] T_CLS   = TW'(CLASS_CYC - 1);
  localparam logic [TW-1:0] T_RAMP  = TW'(RAMP_CYC - 1);
  localparam logic [TW-1:0] T_DISC  = TW'(DISC_CYC - 1);
  localparam logic [TW-1:0] T_BOFF  = TW'(BACKOFF_CYC - 1);
  localparam logic [TW-1:0] T_RBOFF = TW'(RST_BACKOFF_CYC - 1);
  localparam logic [TW-1:0] T_BLINK = TW'(BLINK_HALF_CYC - 1);
  localparam logic [7:0]    T_CONV  = 8'(CONV_HALF_CYC - 1);

  logic [9:0] meta_reg;
  logic [9:0] sync_reg;
  logic [`STRAP_W-1:0] strap_m_reg;
  logic [`STRAP_W-1:0] strap_s_reg;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_reg    <= 10'h000;
      sync_reg    <= 10'h000;
      strap_m_reg <= '0;
      strap_s_reg <= '0;
    end else begin
      meta_reg    <= {i_strap_valid, i_undervoltage_lockout, i_valid_signature_window,
                      i_class_current_sense, i_over_threshold, i_below_hold_current,
                      i_over_power, i_ramp_done, i_open_circuit};
      sync_reg    <= meta_reg;
      strap_m_reg <= i_strap_level;
      strap_s_reg <= strap_m_reg;
    end
  end

  wire            s_strap_valid = sync_reg[9];
  wire            s_undervoltage_lockout        = sync_reg[8];
  wire            s_sig_ok      = sync_reg[7];
  wire [1:0]      s_cls         = sync_reg[6:5];
  wire            s_over        = sync_reg[4];
  wire            s_low_i       = sync_reg[3];
  wire            s_over_pwr    = sync_reg[2];
  wire            s_ramp_done   = sync_reg[1];
  wire            s_open        = sync_reg[0];

  // ----------------------------------------------------------------
  // Strap decode
  // ----------------------------------------------------------------
  // Rows: 0..2 auto endpoint, 3..5 reset endpoint, 6..8 reset midspan,
  // 9..11 auto midspan; levels rise with the row in endpoint rows, fall in midspan rows.
  function automatic logic [3:0] strap_decode(input logic [`STRAP_W-1:0] row);
    logic [1:0] lvl;
    logic       mid;
    logic       on_rst;
    lvl = 2'b00;
    mid = 1'b0;
    on_rst = 1'b0;
    case (row)
      4'h0:    begin lvl = 2'b00; mid = 1'b0; on_rst = 1'b0; end
      4'h1:    begin lvl = 2'b01; mid = 1'b0; on_rst = 1'b0; end
      4'h2:    begin lvl = 2'b10; mid = 1'b0; on_rst = 1'b0; end
      4'h3:    begin lvl = 2'b00; mid = 1'b0; on_rst = 1'b1; end
      4'h4:    begin lvl = 2'b01; mid = 1'b0; on_rst = 1'b1; end
      4'h5:    begin lvl = 2'b10; mid = 1'b0; on_rst = 1'b1; end
      4'h6:    begin lvl = 2'b10; mid = 1'b1; on_rst = 1'b1; end
      4'h7:    begin lvl = 2'b01; mid = 1'b1; on_rst = 1'b1; end
      4'h8:    begin lvl = 2'b00; mid = 1'b1; on_rst = 1'b1; end
      4'h9:    begin lvl = 2'b10; mid = 1'b1; on_rst = 1'b0; end
      4'ha:    begin lvl = 2'b01; mid = 1'b1; on_rst = 1'b0; end
      default: begin lvl = 2'b00; mid = 1'b1; on_rst = 1'b0; end
    endcase
    return {lvl, mid, on_rst};
  endfunction : strap_decode

  // Class allowed for level: all / class 1 or 2 / class 1
  function automatic logic class_ok(input logic [1:0] lvl, input logic [1:0] cls);
    return (lvl == 2'(pse_seq_pkg::LVL_15W4)) ||
           (lvl == 2'(pse_seq_pkg::LVL_7W0) &&
            (cls == 2'(pse_seq_pkg::CLS_1) || cls == 2'(pse_seq_pkg::CLS_2))) ||
           (cls == 2'(pse_seq_pkg::CLS_1));
  endfunction : class_ok

  logic       cfg_done_reg;
  logic [1:0] level_reg;
  logic       midspan_reg;
  logic       on_rst_reg;
  wire  [3:0] strap_dec = strap_decode(strap_s_reg);

  // One-shot strap capture after reset release
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_done_reg <= 1'b0;
      level_reg    <= 2'b00;
      midspan_reg  <= 1'b0;
      on_rst_reg   <= 1'b0;
    end else if (!cfg_done_reg && s_strap_valid) begin
      cfg_done_reg <= 1'b1;
      level_reg    <= strap_dec[3:2];
      midspan_reg  <= strap_dec[1];
      on_rst_reg   <= strap_dec[0];
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  pse_seq_pkg::seq_state_t state_reg;
  pse_seq_pkg::seq_state_t state_next;
  logic [TW-1:0] tmr_reg;
  logic [TW-1:0] per_reg;
  logic [TW-1:0] disc_reg;
  logic [1:0]    class_reg;
  logic          wait_open_reg;
  oc_timer_if    oci ();

  wire tmr_hit  = (state_reg == pse_seq_pkg::ST_ZERO  && tmr_reg == T_ZERO)  ||
                  (state_reg == pse_seq_pkg::ST_STEP1 && tmr_reg == T_STEP)  ||
                  (state_reg == pse_seq_pkg::ST_STEP2 && tmr_reg == T_STEP)  ||
                  (state_reg == pse_seq_pkg::ST_STEP3 && tmr_reg == T_STEP)  ||
                  (state_reg == pse_seq_pkg::ST_CLASS && tmr_reg == T_CLS)   ||
                  (state_reg == pse_seq_pkg::ST_RAMP  && tmr_reg == T_RAMP)  ||
                  (state_reg == pse_seq_pkg::ST_ERROR &&
                   tmr_reg == (on_rst_reg ? T_RBOFF : T_BOFF))               ||
                  (state_reg == pse_seq_pkg::ST_BACKOFF &&
                   tmr_reg == (midspan_reg ? T_BOFF : T_ZERO));
  wire per_hit  = (per_reg >= T_PER);
  wire powered  = (state_reg == pse_seq_pkg::ST_POWERED);
  wire disc_hit = powered && s_low_i && (disc_reg == T_DISC);
  // Overpower, overcurrent or undervoltage while ramping or powered
  wire run_fault = oci.fault || s_over_pwr || s_undervoltage_lockout;

  assign oci.run  = powered || state_reg == pse_seq_pkg::ST_RAMP;
  assign oci.over = s_over;

  oc_timer #(.OC_CYC(OC_CYC)) u_oc (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .tif    (oci)
  );

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      // Leave idle only past undervoltage threshold
      pse_seq_pkg::ST_OFF:
        if (cfg_done_reg && !s_undervoltage_lockout) state_next = pse_seq_pkg::ST_ZERO;
      pse_seq_pkg::ST_ZERO:
        if (s_undervoltage_lockout) state_next = pse_seq_pkg::ST_ERROR;
        else if (tmr_hit) state_next = pse_seq_pkg::ST_STEP1;
      pse_seq_pkg::ST_STEP1:
        if (s_undervoltage_lockout) state_next = pse_seq_pkg::ST_ERROR;
        else if (tmr_hit) state_next = pse_seq_pkg::ST_STEP2;
      pse_seq_pkg::ST_STEP2:
        if (s_undervoltage_lockout) state_next = pse_seq_pkg::ST_ERROR;
        else if (tmr_hit) state_next = pse_seq_pkg::ST_STEP3;
      pse_seq_pkg::ST_STEP3:
        if (s_undervoltage_lockout) state_next = pse_seq_pkg::ST_ERROR;
        // Good signature wins unless waiting to see the port open, else wait out the period
        else if (tmr_hit && s_sig_ok && !wait_open_reg) state_next = pse_seq_pkg::ST_CLASS;
        else if (tmr_hit) state_next = pse_seq_pkg::ST_DET_WAIT;
      // Next attempt on the 320 ms period
      pse_seq_pkg::ST_DET_WAIT:
        if (s_undervoltage_lockout) state_next = pse_seq_pkg::ST_ERROR;
        else if (per_hit) state_next = pse_seq_pkg::ST_ZERO;
      pse_seq_pkg::ST_CLASS:
        if (s_undervoltage_lockout) state_next = pse_seq_pkg::ST_ERROR;
        else if (tmr_hit && class_ok(level_reg, s_cls)) state_next = pse_seq_pkg::ST_RAMP;
        else if (tmr_hit) state_next = pse_seq_pkg::ST_ERROR;
      pse_seq_pkg::ST_RAMP:
        if (run_fault) state_next = pse_seq_pkg::ST_ERROR;
        else if (s_ramp_done || tmr_hit) state_next = pse_seq_pkg::ST_POWERED;
      // Stay on until a cause to stop
      pse_seq_pkg::ST_POWERED:
        if (run_fault) state_next = pse_seq_pkg::ST_ERROR;
        // Disconnect after 350 ms low current
        else if (disc_hit) state_next = pse_seq_pkg::ST_BACKOFF;
      // Two seconds of rapid blink (2.2 s in restart-on-reset mode), then redetect
      pse_seq_pkg::ST_ERROR:
        if (tmr_hit) state_next = pse_seq_pkg::ST_ZERO;
      pse_seq_pkg::ST_BACKOFF:
        if (tmr_hit) state_next = pse_seq_pkg::ST_ZERO;
      default: state_next = pse_seq_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= pse_seq_pkg::ST_OFF;
      tmr_reg   <= '0;
    end else begin
      state_reg <= state_next;
      tmr_reg   <= (state_next != state_reg) ? '0 : tmr_reg + TW'(1);
    end
  end

  // Attempt period starts with each zero interval
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      per_reg <= '0;
    end else if (state_next == pse_seq_pkg::ST_ZERO && state_reg != pse_seq_pkg::ST_ZERO) begin
      per_reg <= '0;
    end else if (!per_hit) begin
      per_reg <= per_reg + TW'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      disc_reg <= '0;
    end else if (!powered || !s_low_i) begin
      disc_reg <= '0;
    end else if (disc_reg != T_DISC) begin
      disc_reg <= disc_reg + TW'(1);
    end
  end

  // Restart-on-reset mode refuses power until the port is seen open
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wait_open_reg <= 1'b0;
      class_reg     <= 2'b00;
    end else begin
      if (state_next == pse_seq_pkg::ST_ERROR && run_fault && on_rst_reg) begin
        wait_open_reg <= 1'b1;
      end else if (s_open && state_reg != pse_seq_pkg::ST_ERROR) begin
        wait_open_reg <= 1'b0;
      end
      if (state_reg == pse_seq_pkg::ST_CLASS) begin
        class_reg <= s_cls;
      end
    end
  end

  // ----------------------------------------------------------------
  // Converter clock and indicator dividers
  // ----------------------------------------------------------------
  logic [7:0]    conv_div_reg;
  logic          conv_ph_reg;
  logic [TW-1:0] blink_div_reg;
  logic          blink_ph_reg;
  wire sourcing = state_reg == pse_seq_pkg::ST_CLASS || state_reg == pse_seq_pkg::ST_RAMP ||
                  powered;
  wire in_det   = state_reg inside {pse_seq_pkg::ST_ZERO, pse_seq_pkg::ST_STEP1,
                  pse_seq_pkg::ST_STEP2, pse_seq_pkg::ST_STEP3, pse_seq_pkg::ST_DET_WAIT};
  wire is_err   = state_reg == pse_seq_pkg::ST_ERROR;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      conv_div_reg  <= 8'h00;
      conv_ph_reg   <= 1'b0;
      blink_div_reg <= '0;
      blink_ph_reg  <= 1'b0;
    end else begin
      conv_div_reg <= (conv_div_reg == T_CONV) ? 8'h00 : conv_div_reg + 8'h01;
      if (conv_div_reg == T_CONV) conv_ph_reg <= ~conv_ph_reg;
      if (!is_err || blink_div_reg == T_BLINK) blink_div_reg <= '0;
      else blink_div_reg <= blink_div_reg + TW'(1);
      if (!is_err) blink_ph_reg <= 1'b1;
      else if (blink_div_reg == T_BLINK) blink_ph_reg <= ~blink_ph_reg;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_conv_clk            <= 1'b0;
      o_switcher_transistor <= 1'b0;
      o_pass_transistor     <= 1'b0;
      o_det_drive           <= 2'b00;
      o_class_mode          <= 1'b0;
      o_ramp_en             <= 1'b0;
      o_overload_threshold  <= 2'b00;
      o_status_indicator    <= 1'b0;
      o_status_pin_oe_n     <= 1'b1;
      o_class               <= 2'b00;
      o_power_level         <= 2'b00;
      o_midspan             <= 1'b0;
      o_error               <= 1'b0;
    end else begin
      // Converter and pass only after valid detection
      o_conv_clk            <= sourcing && conv_ph_reg;
      o_switcher_transistor <= sourcing;
      o_pass_transistor     <= sourcing;
      o_det_drive <= (state_reg == pse_seq_pkg::ST_STEP2) ? 2'(pse_seq_pkg::DRV_7V5) :
                     (state_reg == pse_seq_pkg::ST_STEP1 ||
                      state_reg == pse_seq_pkg::ST_STEP3) ? 2'(pse_seq_pkg::DRV_4V5) :
                     2'(pse_seq_pkg::DRV_ZERO);
      // 18 V, 75 mA classification mode
      o_class_mode <= state_reg == pse_seq_pkg::ST_CLASS;
      o_ramp_en    <= state_reg == pse_seq_pkg::ST_RAMP || powered;
      // Threshold by class; clamp is fixed
      o_overload_threshold <= (class_reg == 2'(pse_seq_pkg::CLS_1)) ? 2'(pse_seq_pkg::CUT_98) :
                              (class_reg == 2'(pse_seq_pkg::CLS_2)) ? 2'(pse_seq_pkg::CUT_180) :
                              2'(pse_seq_pkg::CUT_400);
      // Pin turns output after strap capture
      o_status_pin_oe_n <= ~cfg_done_reg;
      // Steady when powered, pulse per attempt, blink
      o_status_indicator <= cfg_done_reg && (powered ||
                            (in_det && state_reg == pse_seq_pkg::ST_ZERO &&
                             tmr_reg <= T_STEP) || (is_err && blink_ph_reg));
      o_class       <= class_reg;
      o_power_level <= level_reg;
      o_midspan     <= midspan_reg;
      o_error       <= is_err;
    end
  end
endmodule : pse_port_seq

// ===== verif/pd_model.sv
// Powered device on the cable, as the decoded front-end results.
// Assumes the bench picks signature, class and ramp speed per run.
`timescale 1ns/1ps
module pd_model (
  input  wire logic [1:0] i_det_drive,
  input  wire logic       i_class_mode,
  input  wire logic       i_ramp_en,
  input  wire logic       i_sig_ok,
  input  wire logic [1:0] i_cls,
  input  wire logic       i_slow,
  output logic            o_sig,
  output logic [1:0]      o_cls,
  output logic            o_ramp_done
);
  // decoded inputs
  // Outside its phase the signature and class results are inverted, so a stale read shows
  assign o_sig       = (i_det_drive != 2'h0) ? i_sig_ok : ~i_sig_ok;
  assign o_cls       = i_class_mode ? i_cls : ~i_cls;
  // A slow ramp never reports done, leaving the sequencer's own timeout
  assign o_ramp_done = i_ramp_en & ~i_slow;
endmodule : pd_model

// ===== verif/pse_seq_chk.sv
// Checker for the port sequencer, bound to its top ports.
// Assumes the shortened timing of the bench: zero 20, step 8.
`timescale 1ns/1ps
module pse_seq_chk (
  input wire logic       i_clk,
  input wire logic       i_nrst,
  input wire logic       o_conv_clk,
  input wire logic       o_switcher_transistor,
  input wire logic       o_pass_transistor,
  input wire logic [1:0] o_det_drive,
  input wire logic       o_class_mode,
  input wire logic       o_ramp_en,
  input wire logic [1:0] o_overload_threshold,
  input wire logic       o_status_pin_oe_n,
  input wire logic [1:0] o_class,
  input wire logic [1:0] o_power_level,
  input wire logic       o_midspan,
  input wire logic       o_error
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_reset_off;
    $rose(i_nrst) |-> !o_pass_transistor && !o_switcher_transistor && !o_conv_clk;
  endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("power stage live at reset exit");
  property p_strap_once;
    !o_status_pin_oe_n && $past(!o_status_pin_oe_n)
      |=> !o_status_pin_oe_n && $stable(o_power_level) && $stable(o_midspan);
  endproperty
  a_strap_once: assert property (p_strap_once)
    else $error("strap decode changed after capture");
  property p_det_no_pass;
    o_det_drive != 2'h0 |-> !o_pass_transistor && !o_conv_clk;
  endproperty
  a_det_no_pass: assert property (p_det_no_pass)
    else $error("pass or clock on during detection");
  property p_zero_len;
    o_det_drive == 2'h1 && $past(o_det_drive) == 2'h0
      |-> $past(o_det_drive, 20) == 2'h0 && $past(o_det_drive, 10) == 2'h0;
  endproperty
  a_zero_len: assert property (p_zero_len)
    else $error("zero interval too short");
  property p_steps;
    o_det_drive == 2'h1 && $past(o_det_drive) == 2'h0
      |-> (o_det_drive == 2'h1)[*8] ##1 (o_det_drive == 2'h2)[*8] ##1 o_det_drive == 2'h1;
  endproperty
  a_steps: assert property (p_steps)
    else $error("detection step order or length wrong");
  property p_class_entry;
    $rose(o_class_mode) |-> o_pass_transistor && o_switcher_transistor;
  endproperty
  a_class_entry: assert property (p_class_entry)
    else $error("classification without pass on");
  property p_cut_sel;
    o_ramp_en && $past(o_ramp_en) |-> o_overload_threshold ==
      (o_class == 2'h1 ? 2'h1 : (o_class == 2'h2 ? 2'h2 : 2'h0));
  endproperty
  a_cut_sel: assert property (p_cut_sel)
    else $error("overload threshold does not match class");
  property p_err_off;
    o_error |=> !o_pass_transistor && !o_conv_clk;
  endproperty
  a_err_off: assert property (p_err_off)
    else $error("port still powered in error");
  property p_clk_gate;
    o_conv_clk |-> o_switcher_transistor;
  endproperty
  a_clk_gate: assert property (p_clk_gate)
    else $error("converter clock outlives switcher");
endmodule : pse_seq_chk

// ===== verif/poe_pse_port_sequencer_bench.sv
// Self-checking bench for the port sequencer, shortened timing.
// Assumes pd_model answers signature, class and ramp from the port.
`timescale 1ns/1ps
module poe_pse_port_sequencer_bench;
  logic       i_clk, i_nrst, i_strap_valid, i_open_circuit;
  logic       i_undervoltage_lockout, i_over_threshold, i_over_power;
  logic       i_below_hold_current, sig_ok, slow;
  logic [3:0] i_strap_level;
  logic [1:0] cls, i_class_current_sense, o_det_drive, o_overload_threshold;
  logic [1:0] o_class, o_power_level, cut_tab [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  logic       i_valid_signature_window, i_ramp_done, o_conv_clk, o_switcher_transistor;
  logic       o_pass_transistor, o_class_mode, o_ramp_en, o_status_indicator;
  logic       o_status_pin_oe_n, o_midspan, o_error;
  int         fails = 0;
  int         cmp_count = 0;

  pse_port_seq #(.ZERO_CYC(20), .STEP_CYC(8), .DET_PERIOD_CYC(60), .CLASS_CYC(8),
    .RAMP_CYC(10), .OC_CYC(32), .DISC_CYC(30), .BACKOFF_CYC(40), .RST_BACKOFF_CYC(44),
    .BLINK_HALF_CYC(4), .CONV_HALF_CYC(2)) dut (.*);
  pd_model pd (.i_det_drive(o_det_drive), .i_class_mode(o_class_mode), .i_ramp_en(o_ramp_en),
    .i_sig_ok(sig_ok), .i_cls(cls), .i_slow(slow), .o_sig(i_valid_signature_window),
    .o_cls(i_class_current_sense), .o_ramp_done(i_ramp_done));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    fails++;
    final_report();
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, want, seen);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask : tick
  // Strap is only taken after reset, so every scenario starts here
  task automatic start(input logic [3:0] row, input logic [1:0] c, input logic ok, s);
    i_nrst = 1'b0;
    {i_strap_level, cls, sig_ok, slow} = {row, c, ok, s};
    {i_undervoltage_lockout, i_over_threshold, i_below_hold_current, i_over_power} = 4'h0;
    {i_open_circuit, i_strap_valid} = 2'h0;
    tick(3);
    i_nrst = 1'b1;
    tick(4);
    check("pin_in", o_status_pin_oe_n, 1'b1);
    i_strap_valid = 1'b1;
  endtask : start
  task automatic led_gap(output int n);
    n = 0;
    while (o_status_indicator !== 1'b0 && n < 200) begin
      tick(1);
      n++;
    end
    while (o_status_indicator !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
  endtask : led_gap
  task automatic t_search;
    int n;
    start(4'hb, 2'h0, 1'b0, 1'b0);
    tick(40);
    check("level", o_power_level, 2'h0);
    check("midspan", o_midspan, 1'b1);
    check("pin_oe_n", o_status_pin_oe_n, 1'b0);
    i_strap_level = 4'h2;
    led_gap(n);
    led_gap(n);
    check("attempt_gap", 8'(n), 8'h3c);
    check("level_kept", o_power_level, 2'h0);
    check("pass_search", o_pass_transistor, 1'b0);
  endtask : t_search
  task automatic t_grant(input logic [1:0] c, input logic [1:0] cut, input logic s,
      input logic [3:0] r);
    start(r, c, 1'b1, s);
    tick(90);
    check("class", o_class, c);
    check("cut", o_overload_threshold, cut);
    check("led_on", o_status_indicator, 1'b1);
    check("pass_on", o_pass_transistor, 1'b1);
  endtask : t_grant
  task automatic t_trip(input logic uv);
    t_grant(2'h2, 2'h2, 1'b0, {2'h0, uv, uv});
    {i_undervoltage_lockout, i_over_power} = uv ? 2'h2 : 2'h1;
    tick(8);
    check("trip_err", o_error, 1'b1);
    check("trip_pass", o_pass_transistor, 1'b0);
    {i_undervoltage_lockout, i_over_power} = 2'h0;
    tick(37);
    check("restart", o_error, uv);
    tick(55);
    check("lock", o_pass_transistor, !uv);
    i_open_circuit = 1'b1;
    tick(77);
    check("unlock", o_pass_transistor, 1'b1);
  endtask : t_trip
  // Down-counting at a sixteenth keeps most of the first burst
  task automatic t_oc;
    t_grant(2'h1, 2'h1, 1'b1, 4'h0);
    i_over_threshold = 1'b1;
    tick(20);
    check("oc_early", o_error, 1'b0);
    i_over_threshold = 1'b0;
    tick(32);
    i_over_threshold = 1'b1;
    tick(26);
    check("oc_trip", o_error, 1'b1);
  endtask : t_oc
  task automatic t_misc;
    t_grant(2'h0, 2'h0, 1'b0, 4'h0);
    i_below_hold_current = 1'b1;
    tick(24);
    check("disc_early", o_switcher_transistor, 1'b1);
    tick(14);
    check("disc_off", o_switcher_transistor, 1'b0);
    check("disc_err", o_error, 1'b0);
    start(4'h2, 2'h2, 1'b1, 1'b0);
    tick(80);
    check("deny_err", o_error, 1'b1);
    check("deny_pass", o_pass_transistor, 1'b0);
    tick(30);
    check("deny_end", o_error, 1'b0);
  endtask : t_misc

  initial begin
    t_search();
    for (int c = 0; c < 4; c++) begin
      t_grant(2'(c), cut_tab[c], c == 3, 4'h0);
    end
    t_trip(1'b0);
    t_trip(1'b1);
    t_oc();
    t_misc();
    final_report();
  end
endmodule : poe_pse_port_sequencer_bench

bind pse_port_seq pse_seq_chk chk (.*);
